// *** verilog/fpc_regs.sv ***
// Purpose: synthesizer loop configuration register bank
// Assumes: one clock, strobes one cycle long, never both at once
// Notes: all outputs registered; read data valid the cycle after read
`timescale 1ns/1ps
module fpc_regs
    import fpc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [FPC_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output fpc_ctl_t ctl
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg, next_ctrl_reg;
    logic [7:0] path_reg, next_path_reg;
    logic [7:0] pump_reg, next_pump_reg;
    fpc_filter_t filt_reg, next_filt_reg;
    logic [7:0] next_rdata;
    fpc_ctl_t next_ctl;
    logic [11:0] dec_rp2;
    logic [12:0] dec_rz;
    logic [7:0] dec_cp1;
    logic [9:0] dec_ua;

    function automatic logic hit(input logic [FPC_AW-1:0] a, input logic [11:0] o);
        return a == o;
    endfunction : hit

    always_comb begin
        next_ctrl_reg = ctrl_reg;
        next_path_reg = path_reg;
        next_pump_reg = pump_reg;
        next_filt_reg = filt_reg;
        if (wr && hit(addr, FPC_OFS_CTRL)) begin
            next_ctrl_reg = wdata & FPC_CTRL_MASK; // [RQ11]
        end
        if (wr && hit(addr, FPC_OFS_PATH)) begin
            next_path_reg = wdata & FPC_PATH_MASK; // [RQ11]
        end
        if (wr && hit(addr, FPC_OFS_PUMP)) begin
            next_pump_reg = wdata; // [RQ7]
        end
        if (wr && hit(addr, FPC_OFS_FILT)) begin
            next_filt_reg = fpc_filter_t'(wdata); // [RQ8] [RQ9] [RQ10]
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_reg <= FPC_CTRL_RST;
            path_reg <= FPC_PATH_RST; // [RQ6]
            pump_reg <= FPC_PUMP_RST; // [RQ7]
            filt_reg <= {FPC_RP2_RST, FPC_RZ_RST, FPC_CP1_RST};
        end else begin
            ctrl_reg <= next_ctrl_reg;
            path_reg <= next_path_reg;
            pump_reg <= next_pump_reg;
            filt_reg <= next_filt_reg;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            if (hit(addr, FPC_OFS_CTRL)) begin
                next_rdata = ctrl_reg;
            end else if (hit(addr, FPC_OFS_PATH)) begin
                next_rdata = path_reg;
            end else if (hit(addr, FPC_OFS_PUMP)) begin
                next_rdata = pump_reg;
            end else if (hit(addr, FPC_OFS_FILT)) begin
                next_rdata = filt_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    fpc_filter_decode u_dec (
        .filt(filt_reg),
        .pump_code(pump_reg),
        .rp2_ohm(dec_rp2),
        .rz_ohm(dec_rz),
        .cp1_pf(dec_cp1),
        .pump_ua(dec_ua)
    );

    always_comb begin
        next_ctl = '0;
        // Edge compare on stored value, so rewriting a one starts nothing
        next_ctl.cal_start = next_ctrl_reg[FPC_CAL_BIT] & ~ctrl_reg[FPC_CAL_BIT]; // [RQ1]
        next_ctl.div_sync = next_ctrl_reg[FPC_SYNC_BIT]; // [RQ2]
        next_ctl.loop_pd = next_ctrl_reg[FPC_PD_BIT]; // [RQ3]
        next_ctl.loop_reset = next_ctrl_reg[FPC_RST_BIT]; // [RQ3]
        next_ctl.dbl_sel = next_path_reg[FPC_DBL_BIT]; // [RQ4]
        next_ctl.loop_mode = fpc_mode_t'(next_path_reg[FPC_MODE_HI:FPC_MODE_LO]); // [RQ5]
        // Reserved mode flagged; loop_mode still passes the reserved code out
        next_ctl.mode_bad = (next_path_reg[FPC_MODE_HI:FPC_MODE_LO] == FPC_MODE_RSVD); // [RQ5]
        next_ctl.mod_pd = next_path_reg[FPC_MPD_BIT]; // [RQ6]
        next_ctl.pump_code = pump_reg;
        next_ctl.pump_ua = dec_ua;
        next_ctl.rp2_ohm = dec_rp2;
        next_ctl.rz_ohm = dec_rz;
        next_ctl.cp1_pf = dec_cp1;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctl <= '0;
            ctl.mod_pd <= 1'b1;
            ctl.pump_code <= FPC_PUMP_RST;
            ctl.pump_ua <= 10'd564;
            ctl.rp2_ohm <= 12'd285;
            ctl.rz_ohm <= 13'd3375;
            ctl.cp1_pf <= 8'd2;
        end else begin
            ctl <= next_ctl;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cal_pulse_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ1]
        (wr && addr == FPC_OFS_CTRL && wdata[3] && !ctrl_reg[3]) |=> ctl.cal_start)
        else $error("calibration not started");
    cal_single_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ1]
        ctl.cal_start |=> !ctl.cal_start)
        else $error("calibration pulse too long");
    sync_follow_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ2]
        ##1 ctl.div_sync == $past(next_ctrl_reg[2]))
        else $error("sync not following control");
    pd_rst_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ3]
        (wr && addr == FPC_OFS_CTRL) |=> (ctl.loop_pd == $past(wdata[1])
            && ctl.loop_reset == $past(wdata[0])))
        else $error("power-down or reset wrong");
    dbl_path_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ4]
        (wr && addr == FPC_OFS_PATH) |=> ctl.dbl_sel == $past(wdata[3]))
        else $error("doubler select wrong");
    mode_sel_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ5]
        ctl.mode_bad == (ctl.loop_mode == FPC_MODE_RSVD))
        else $error("reserved mode flag wrong");
    mod_pd_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ6]
        (wr && addr == FPC_OFS_PATH) |=> ctl.mod_pd == $past(wdata[0]))
        else $error("modulator power-down wrong");
    pump_ua_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
        ctl.pump_ua == {ctl.pump_code, 2'b00})
        else $error("pump current wrong");
    rp2_map_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        (wr && addr == FPC_OFS_FILT && wdata[7:6] == 2'h1) |=> ##1 ctl.rp2_ohm == 12'd666)
        else $error("second-pole resistor wrong");
    rz_map_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ9]
        (wr && addr == FPC_OFS_FILT && wdata[5:3] == 3'h3) |=> ##1 ctl.rz_ohm == 13'd2650)
        else $error("zero resistor wrong");
    cp1_map_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ10]
        (wr && addr == FPC_OFS_FILT && wdata[2:0] == 3'h6) |=> ##1 ctl.cp1_pf == 8'd122)
        else $error("first-pole capacitor wrong");
    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // [RQ11]
        (rd && (addr == FPC_OFS_CTRL || addr == FPC_OFS_PATH)) |=> rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    read_back_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr && addr == FPC_OFS_PUMP) ##1 (rd && addr == FPC_OFS_PUMP)
            |=> rdata == $past(wdata, 2))
        else $error("pump read-back wrong");

    cal_cov: cover property (@(posedge clk_sys) disable iff (reset) ctl.cal_start);
    mode_cov: cover property (@(posedge clk_sys) disable iff (reset)
        ctl.loop_mode == FPC_MODE_FIXDLY);
    sync_cov: cover property (@(posedge clk_sys) disable iff (reset)
        ctl.div_sync ##1 !ctl.div_sync);
    filt_cov: cover property (@(posedge clk_sys) disable iff (reset)
        rd && addr == FPC_OFS_FILT);
endmodule : fpc_regs

// *** verilog/fpc_pkg.sv ***
// Purpose: constants and types for the synthesizer loop configuration registers
// Assumes: plain register port, 8-bit registers at their printed offsets
// Notes: analog settings leave the block as decoded codes
// Behaviour
// RQ1 - Calibration starts on control bit 3 rising
// RQ2 - Bit 2 holds loop dividers in sync
// RQ3 - Bit 1 powers down, bit 0 resets
// RQ4 - Path bit 3 selects doubled reference
// RQ5 - Loop mode field selects feedback path
// RQ6 - Modulator power-down bit resets to one
// RQ7 - Pump code, 4 uA/step, resets 0x8d
// RQ8 - Filter bits 7:6 pick second-pole resistor
// RQ9 - Filter bits 5:3 pick zero resistor
// RQ10 - Filter bits 2:0 pick first-pole capacitor
// RQ11 - Reserved control bits read zero, ignore writes
package fpc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int FPC_AW = 12;
    localparam logic [11:0] FPC_OFS_CTRL = 12'h100;
    localparam logic [11:0] FPC_OFS_PATH = 12'h101;
    localparam logic [11:0] FPC_OFS_PUMP = 12'h102;
    localparam logic [11:0] FPC_OFS_FILT = 12'h103;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int FPC_CAL_BIT = 3;
    localparam int FPC_SYNC_BIT = 2;
    localparam int FPC_PD_BIT = 1;
    localparam int FPC_RST_BIT = 0;
    localparam int FPC_DBL_BIT = 3;
    localparam int FPC_MODE_HI = 2;
    localparam int FPC_MODE_LO = 1;
    localparam int FPC_MPD_BIT = 0;
    localparam logic [7:0] FPC_CTRL_RST = 8'h00;
    localparam logic [7:0] FPC_PATH_RST = 8'h01;
    localparam logic [7:0] FPC_PUMP_RST = 8'h8d;
    localparam logic [1:0] FPC_RP2_RST = 2'h3;
    localparam logic [2:0] FPC_RZ_RST = 3'h5;
    localparam logic [2:0] FPC_CP1_RST = 3'h0;
    localparam logic [7:0] FPC_CTRL_MASK = 8'h0f;
    localparam logic [7:0] FPC_PATH_MASK = 8'h0f;
    localparam int FPC_PUMP_UA_STEP = 4;
    localparam int FPC_PUMP_UA_W = 10;

    typedef enum logic [1:0] {
        FPC_MODE_SINGLE = 2'h0,
        FPC_MODE_CASCADE = 2'h1,
        FPC_MODE_FIXDLY = 2'h2,
        FPC_MODE_RSVD = 2'h3
    } fpc_mode_t;

    typedef struct packed {
        logic [1:0] second_pole_resistor;
        logic [2:0] zero_resistor;
        logic [2:0] first_pole_capacitor;
    } fpc_filter_t;

    typedef struct packed {
        logic cal_start;
        logic div_sync;
        logic loop_pd;
        logic loop_reset;
        logic dbl_sel;
        fpc_mode_t loop_mode;
        logic mode_bad;
        logic mod_pd;
        logic [7:0] pump_code;
        logic [9:0] pump_ua;
        logic [11:0] rp2_ohm;
        logic [12:0] rz_ohm; // Widest value 4125 needs 13 bits
        logic [7:0] cp1_pf;
    } fpc_ctl_t;
endpackage : fpc_pkg

// *** verilog/fpc_filter_decode.sv ***
// Purpose: turn filter and pump codes into physical values
// Assumes: codes come from registers on the same clock
// Notes: combinational; the top registers the results
`timescale 1ns/1ps
module fpc_filter_decode
    import fpc_pkg::*;
(
    input wire fpc_filter_t filt,
    input wire logic [7:0] pump_code,
    output logic [11:0] rp2_ohm,
    output logic [12:0] rz_ohm,
    output logic [7:0] cp1_pf,
    output logic [9:0] pump_ua
);
    always_comb begin
        unique case (filt.second_pole_resistor) // [RQ8]
            2'h0: rp2_ohm = 12'd2000;
            2'h1: rp2_ohm = 12'd666;
            2'h2: rp2_ohm = 12'd400;
            2'h3: rp2_ohm = 12'd285;
        endcase
        unique case (filt.zero_resistor) // [RQ9]
            3'h0: rz_ohm = 13'd1500;
            3'h1: rz_ohm = 13'd1875;
            3'h2: rz_ohm = 13'd2250;
            3'h3: rz_ohm = 13'd2650;
            3'h4: rz_ohm = 13'd3000;
            3'h5: rz_ohm = 13'd3375;
            3'h6: rz_ohm = 13'd3750;
            3'h7: rz_ohm = 13'd4125;
        endcase
        unique case (filt.first_pole_capacitor) // [RQ10]
            3'h0: cp1_pf = 8'd2;
            3'h1: cp1_pf = 8'd8;
            3'h2: cp1_pf = 8'd42;
            3'h3: cp1_pf = 8'd48;
            3'h4: cp1_pf = 8'd82;
            3'h5: cp1_pf = 8'd88;
            3'h6: cp1_pf = 8'd122;
            3'h7: cp1_pf = 8'd128;
        endcase
        pump_ua = {pump_code, 2'b00}; // [RQ7] times FPC_PUMP_UA_STEP
    end
endmodule : fpc_filter_decode

// *** testbench/fpc_regs_test.sv ***
// Purpose: self-checking bench for the synthesizer loop configuration registers
// Assumes: one clock, strobes driven by non-blocking assignment after rising edges
// Notes: each scenario is a task that drives the bank and judges its own results
`timescale 1ns/1ps
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module fpc_regs_test
    import fpc_pkg::*;
;
    logic clk_sys;
    logic reset;
    logic [FPC_AW-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    fpc_ctl_t ctl;
    int fail_count;
    int compares;
    logic [15:0] rp2_tab [4] = '{16'h07d0, 16'h029a, 16'h0190, 16'h011d};
    logic [15:0] rz_tab [8] = '{16'h05dc, 16'h0753, 16'h08ca, 16'h0a5a,
                                16'h0bb8, 16'h0d2f, 16'h0ea6, 16'h101d};
    logic [7:0] cp_tab [8] = '{8'h02, 8'h08, 8'h2a, 8'h30, 8'h52, 8'h58, 8'h7a, 8'h80};

    fpc_regs i_fpc_regs (
        .clk_sys(clk_sys),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .ctl(ctl)
    );

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Both tasks end one step after the edge so outputs have settled
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask : rd_chk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        rd_chk(FPC_OFS_CTRL, 8'h00);
        rd_chk(FPC_OFS_PATH, 8'h01);
        rd_chk(FPC_OFS_PUMP, 8'h8d);
        rd_chk(FPC_OFS_FILT, 8'he8);
        rd_chk(12'h104, 8'h00);
        `CHK(ctl.mod_pd, 1'b1)
        `CHK(ctl.pump_ua, 10'h234)
        `CHK(ctl.rp2_ohm, rp2_tab[3])
        `CHK(ctl.rz_ohm, rz_tab[5])
        `CHK(ctl.cp1_pf, cp_tab[0])
    endtask : test_reset_values

    task automatic test_control();
        wr_reg(FPC_OFS_CTRL, 8'h08);
        `CHK(ctl.cal_start, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHK(ctl.cal_start, 1'b0)
        // Holding the bit high must not retrigger
        wr_reg(FPC_OFS_CTRL, 8'h08);
        `CHK(ctl.cal_start, 1'b0)
        wr_reg(FPC_OFS_CTRL, 8'hf7);
        `CHK(ctl.cal_start, 1'b0)
        `CHK(ctl.div_sync, 1'b1)
        `CHK(ctl.loop_pd, 1'b1)
        `CHK(ctl.loop_reset, 1'b1)
        rd_chk(FPC_OFS_CTRL, 8'h07);
        wr_reg(FPC_OFS_CTRL, 8'h09);
        `CHK(ctl.cal_start, 1'b1)
        `CHK(ctl.div_sync, 1'b0)
        `CHK(ctl.loop_pd, 1'b0)
        wr_reg(FPC_OFS_CTRL, 8'h00);
        `CHK(ctl.cal_start, 1'b0)
        `CHK(ctl.loop_reset, 1'b0)
    endtask : test_control

    task automatic test_path();
        logic [1:0] m;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            d = {4'ha, m[0], m, ~m[0]};
            wr_reg(FPC_OFS_PATH, d);
            `CHK(ctl.dbl_sel, m[0])
            `CHK(ctl.loop_mode, m)
            `CHK(ctl.mode_bad, (m == 2'h3))
            `CHK(ctl.mod_pd, ~m[0])
            rd_chk(FPC_OFS_PATH, {4'h0, d[3:0]});
        end
    endtask : test_path

    task automatic test_pump();
        // Pump code and current both follow the register one cycle late
        wr_reg(FPC_OFS_PUMP, 8'hff);
        @(posedge clk_sys);
        #1;
        `CHK(ctl.pump_code, 8'hff)
        `CHK(ctl.pump_ua, 10'h3fc)
        // Unmapped write must leave the bank alone
        wr_reg(12'h104, 8'h00);
        rd_chk(FPC_OFS_PUMP, 8'hff);
    endtask : test_pump

    task automatic test_filter();
        logic [2:0] c;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            d = {c[1:0], c, 3'(7 - i)};
            wr_reg(FPC_OFS_FILT, d);
            @(posedge clk_sys);
            #1;
            `CHK(ctl.rp2_ohm, rp2_tab[i % 4])
            `CHK(ctl.rz_ohm, rz_tab[i])
            `CHK(ctl.cp1_pf, cp_tab[7 - i])
            rd_chk(FPC_OFS_FILT, d);
        end
    endtask : test_filter

    // ------------------------------------------------------------
    // Verdict, clock, reset and watchdog
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Tests need under a hundred cycles; allow ample margin
    initial begin
        #(4000 * 50);
        fail_count++;
        print_verdict();
    end

    initial begin
        fail_count = 0;
        compares = 0;
        reset = 1'b1;
        addr = 12'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        test_reset_values();
        test_control();
        test_path();
        test_pump();
        test_filter();
        print_verdict();
    end
endmodule : fpc_regs_test
